// file: logic/stc_regs.vh
// register layout and constants for the synchronous transmitter control block
`ifndef STC_REGS_VH
`define STC_REGS_VH
`define STC_BIT_FILL_SENT     15
`define STC_BIT_LOOP_DATA     14
`define STC_BIT_MSTR_RESET    8
`define STC_BIT_TX_DONE       7
`define STC_BIT_TX_IRQ_EN     6
`define STC_BIT_FILL_IRQ_EN   5
`define STC_BIT_SEND          4
`define STC_BIT_HALF_DUPLEX   3
`define STC_BIT_FORCE_SPACE   0
`define STC_DBUF_RESET        8'hFF
`define STC_FILL_CHAR         8'h96
`define STC_VEC_RX_DEFAULT    6'h00
`define STC_VEC_TX_DEFAULT    6'h01
`define STC_PRIO_DEFAULT      3'h5
`define STC_BIT_CLKS          4'h4
`endif

// file: logic/stc_tx_ctrl.v
// transmitter control, data buffer, serializer and interrupt request logic
//
// How it works
// - tx done raises transmitter request only while tx_irq_enable is set
// - fill-sent raises transmitter request only while fill_sent_irq_enable is set
// - control bits read/write, cleared by init pulse or master reset
// - with send set, writing the data buffer starts serial transmission
// - send cleared mid-message: current character finishes, then idle
// - half duplex with send set disables the receiver
// - forced-space bit holds serial output low
// - data buffer bits 7..0, write-only, right-justified 5..8 bit character
// - parity computed and appended by the device
// - init or master reset loads the data buffer with all ones
// - requests via bus request line, vector given on grant
// - separate receiver and transmitter vectors
// - receiver request served first when both pending
// - receiver request from received-char or modem-change flags with enables
// - request level defaults to five, set by a strap input
// - vector addresses selectable by strap inputs
// - tx done set on reset and when first bit goes to line
// - fill-sent set when a fill character is sent in synchronous mode
`timescale 1ns/1ns
`include "stc_regs.vh"
module stc_tx_ctrl
(
    input  wire        sys_clk,
    input  wire        reset_n,
    input  wire        bus_init,
    input  wire        csr_wr,
    input  wire [15:0] csr_wdata,
    input  wire        csr_rd,
    output reg  [15:0] csr_rdata,
    input  wire        dbuf_wr,
    input  wire [7:0]  dbuf_wdata,
    output reg         dbuf_ready,
    input  wire [1:0]  char_len,
    input  wire        parity_en,
    input  wire        parity_odd,
    input  wire        sync_mode,
    input  wire        rx_done_flag,
    input  wire        rx_irq_enable,
    input  wire        modem_status_change_flag,
    input  wire        modem_change_irq_enable,
    input  wire [2:0]  prio_strap,
    input  wire [5:0]  rx_vec_strap,
    input  wire [5:0]  tx_vec_strap,
    input  wire        bus_grant,
    output reg         bus_request,
    output reg  [2:0]  bus_level,
    output reg  [5:0]  irq_vector,
    output reg         irq_vector_valid,
    output reg         serial_out,
    output reg         receiver_disable,
    output reg         loop_test_input_bit
);
    // one-hot serializer states
    localparam ST_IDLE  = 3'b001;
    localparam ST_SHIFT = 3'b010;
    localparam ST_GAP   = 3'b100;

    // control bits written by software
    reg         tx_irq_enable_q;
    reg         fill_sent_irq_enable_q;
    reg         send_q;
    reg         half_duplex_select_q;
    reg         force_space_q;

    // status flags
    reg         tx_done_q;
    reg         fill_sent_flag_q;

    // two-entry character buffer
    reg  [7:0]  buf_data_q [0:1];
    reg  [1:0]  buf_cnt_q;
    reg         buf_rd_q;
    reg         buf_wr_q;
    reg  [7:0]  tx_data_buffer_q;

    // serializer state
    reg  [2:0]  state_q;
    reg  [9:0]  shift_q;
    reg  [3:0]  bits_left_q;
    reg  [3:0]  bit_clk_q;
    reg         line_q;

    // interrupt request state
    reg         rx_req_q;
    reg         prev_done_q;
    reg         prev_fill_q;
    reg         tx_pend_q;

    // combinational helpers
    reg  [15:0] status_d;
    reg         tx_ev;
    reg         clr;
    reg         load_char;
    reg         use_fill;
    reg  [7:0]  next_char;
    reg  [7:0]  masked;
    reg  [3:0]  nbits;
    reg         par;
    integer     i;

    // clear pulse from bus init or the write-only master reset bit
    always @*
    begin
        clr = bus_init | (csr_wr & csr_wdata[`STC_BIT_MSTR_RESET]);
    end

    // character length, parity and the next character selection
    always @*
    begin
        use_fill  = (buf_cnt_q == 2'd0);
        next_char = use_fill ? `STC_FILL_CHAR : buf_data_q[buf_rd_q];
        masked    = next_char;
        for (i = 0; i < 8; i = i + 1)
            if (i > {29'd0, char_len} + 4)
                masked[i] = 1'b0;
        par   = (^masked) ^ parity_odd;
        nbits = {2'b00, char_len} + 4'd5 + {3'b000, parity_en};
        load_char = (state_q == ST_IDLE && send_q && !use_fill) ||
                    (state_q == ST_GAP && send_q && (!use_fill || sync_mode));
    end

    // control bits, loop test bit and flags
    always @(posedge sys_clk)
    begin
        if (!reset_n || clr)
        begin
            tx_irq_enable_q        <= 1'b0;
            fill_sent_irq_enable_q <= 1'b0;
            send_q                 <= 1'b0;
            half_duplex_select_q   <= 1'b0;
            force_space_q          <= 1'b0;
            loop_test_input_bit    <= 1'b0;
            tx_done_q              <= 1'b1;
            fill_sent_flag_q       <= 1'b0;
        end
        else
        begin
            if (csr_wr)
            begin
                tx_irq_enable_q        <= csr_wdata[`STC_BIT_TX_IRQ_EN];
                fill_sent_irq_enable_q <= csr_wdata[`STC_BIT_FILL_IRQ_EN];
                send_q                 <= csr_wdata[`STC_BIT_SEND];
                half_duplex_select_q   <= csr_wdata[`STC_BIT_HALF_DUPLEX];
                force_space_q          <= csr_wdata[`STC_BIT_FORCE_SPACE];
                loop_test_input_bit    <= csr_wdata[`STC_BIT_LOOP_DATA];
            end
            // set wins over the clear on the same cycle
            if (load_char)
                tx_done_q <= 1'b1;
            else if (dbuf_wr && dbuf_ready)
                tx_done_q <= 1'b0;
            if (load_char && use_fill)
                fill_sent_flag_q <= 1'b1;
            else if (csr_rd)
                fill_sent_flag_q <= 1'b0;
        end
    end

    // two-entry data buffer; last written character kept for reset view
    always @(posedge sys_clk)
    begin
        if (!reset_n || clr)
        begin
            tx_data_buffer_q <= `STC_DBUF_RESET;
            buf_data_q[0]    <= `STC_DBUF_RESET;
            buf_data_q[1]    <= `STC_DBUF_RESET;
            buf_cnt_q        <= 2'd0;
            buf_rd_q         <= 1'b0;
            buf_wr_q         <= 1'b0;
            dbuf_ready       <= 1'b0;
        end
        else
        begin
            if (dbuf_wr && dbuf_ready)
            begin
                tx_data_buffer_q     <= dbuf_wdata;
                buf_data_q[buf_wr_q] <= dbuf_wdata;
                buf_wr_q             <= ~buf_wr_q;
            end
            if (load_char && !use_fill)
                buf_rd_q <= ~buf_rd_q;
            buf_cnt_q <= buf_cnt_q + {1'b0, dbuf_wr && dbuf_ready}
                         - {1'b0, load_char && !use_fill};
            dbuf_ready <= (buf_cnt_q + {1'b0, dbuf_wr && dbuf_ready}
                           - {1'b0, load_char && !use_fill}) < 2'd2;
        end
    end

    // serializer: start bit free synchronous shift, lsb first
    always @(posedge sys_clk)
    begin
        if (!reset_n || clr)
        begin
            state_q     <= ST_IDLE;
            shift_q     <= 10'h3FF;
            bits_left_q <= 4'h0;
            bit_clk_q   <= 4'h0;
            line_q      <= 1'b1;
        end
        else
        begin
            case (state_q)
                ST_IDLE, ST_GAP:
                begin
                    if (load_char)
                    begin
                        shift_q     <= {1'b1, 9'h000} | ({2'b00, masked} |
                                       ({9'd0, par & parity_en} << (nbits - 4'd1)));
                        bits_left_q <= nbits;
                        bit_clk_q   <= `STC_BIT_CLKS;
                        state_q     <= ST_SHIFT;
                    end
                    else
                    begin
                        line_q  <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                ST_SHIFT:
                begin
                    line_q <= shift_q[0];
                    if (bit_clk_q == 4'h1)
                    begin
                        bit_clk_q   <= `STC_BIT_CLKS;
                        shift_q     <= {1'b1, shift_q[9:1]};
                        bits_left_q <= bits_left_q - 4'h1;
                        if (bits_left_q == 4'h1)
                            state_q <= ST_GAP;
                    end
                    else
                        bit_clk_q <= bit_clk_q - 4'h1;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // status word assembly, unused bits read as zero
    always @*
    begin
        status_d                        = 16'h0000;
        status_d[`STC_BIT_FILL_SENT]    = fill_sent_flag_q;
        status_d[`STC_BIT_LOOP_DATA]    = loop_test_input_bit;
        status_d[`STC_BIT_TX_DONE]      = tx_done_q;
        status_d[`STC_BIT_TX_IRQ_EN]    = tx_irq_enable_q;
        status_d[`STC_BIT_FILL_IRQ_EN]  = fill_sent_irq_enable_q;
        status_d[`STC_BIT_SEND]         = send_q;
        status_d[`STC_BIT_HALF_DUPLEX]  = half_duplex_select_q;
        status_d[`STC_BIT_FORCE_SPACE]  = force_space_q;
    end

    // line output, receiver lockout and status readback
    always @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            serial_out       <= 1'b1;
            receiver_disable <= 1'b0;
            csr_rdata        <= 16'h0000;
        end
        else
        begin
            serial_out       <= force_space_q ? 1'b0 : line_q;
            receiver_disable <= half_duplex_select_q & send_q;
            csr_rdata        <= status_d;
        end
    end

    // transmitter event on a rising flag edge, gated by its enable
    always @*
    begin
        tx_ev = (tx_done_q & ~prev_done_q & tx_irq_enable_q) |
                (fill_sent_flag_q & ~prev_fill_q & fill_sent_irq_enable_q);
    end

    // previous flag values; done starts high so reset gives no false edge
    always @(posedge sys_clk)
    begin
        if (!reset_n || bus_init)
        begin
            prev_done_q <= 1'b1;
            prev_fill_q <= 1'b0;
        end
        else
        begin
            prev_done_q <= tx_done_q;
            prev_fill_q <= fill_sent_flag_q;
        end
    end

    // receiver request level from its two flag and enable pairs
    always @(posedge sys_clk)
    begin
        if (!reset_n || bus_init)
        begin
            rx_req_q <= 1'b0;
        end
        else
        begin
            rx_req_q <= (rx_done_flag & rx_irq_enable) |
                        (modem_status_change_flag & modem_change_irq_enable);
        end
    end

    // sticky transmitter request, dropped only when its vector is served
    always @(posedge sys_clk)
    begin
        if (!reset_n || bus_init)
        begin
            tx_pend_q <= 1'b0;
        end
        else
        begin
            if (tx_ev)
                tx_pend_q <= 1'b1;
            else if (bus_grant && !rx_req_q && tx_pend_q)
                tx_pend_q <= 1'b0;
        end
    end

    // bus request, level and vector; receiver wins when both pend
    always @(posedge sys_clk)
    begin
        if (!reset_n || bus_init)
        begin
            bus_request      <= 1'b0;
            bus_level        <= `STC_PRIO_DEFAULT;
            irq_vector       <= `STC_VEC_RX_DEFAULT;
            irq_vector_valid <= 1'b0;
        end
        else
        begin
            bus_level        <= prio_strap;
            bus_request      <= (rx_req_q | tx_pend_q) & ~bus_grant;
            irq_vector_valid <= bus_grant & (rx_req_q | tx_pend_q);
            irq_vector       <= rx_req_q ? rx_vec_strap : tx_vec_strap;
        end
    end
endmodule // stc_tx_ctrl

// file: test/stc_tx_monitor.sv
// assertions on the transmitter control block ports
`timescale 1ns/1ns
module stc_tx_monitor
(
    input logic        sys_clk,
    input logic        reset_n,
    input logic        bus_init,
    input logic        csr_wr,
    input logic [15:0] csr_wdata,
    input logic [15:0] csr_rdata,
    input logic        sync_mode,
    input logic        rx_done_flag,
    input logic        rx_irq_enable,
    input logic        bus_grant,
    input logic [2:0]  prio_strap,
    input logic [5:0]  rx_vec_strap,
    input logic [5:0]  tx_vec_strap,
    input logic        bus_request,
    input logic [2:0]  bus_level,
    input logic [5:0]  irq_vector,
    input logic        irq_vector_valid,
    input logic        serial_out,
    input logic        receiver_disable
);
    // all checks on the system clock, off during reset except idle_after_reset_a
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    idle_after_reset_a: assert property (disable iff (1'b0) !reset_n |=> serial_out && !bus_request)
        else $error("line not idle after reset");
    force_space_a: assert property (csr_wr && csr_wdata[0] && !csr_wdata[8] |-> ##[1:3] !serial_out)
        else $error("line not held at space");
    half_duplex_select_lock_a: assert property (csr_wr && csr_wdata[4:3] == 2'b11 && !csr_wdata[8] |-> ##[1:3] receiver_disable)
        else $error("receiver not locked out");
    request_level_a: assert property (bus_request |-> bus_level == prio_strap)
        else $error("wrong request level");
    vector_source_a: assert property (irq_vector_valid |-> irq_vector == rx_vec_strap || irq_vector == tx_vec_strap)
        else $error("vector not from straps");
    vector_after_req_a: assert property (irq_vector_valid |-> $past(bus_request))
        else $error("vector without request");
    rx_first_a: assert property (irq_vector_valid && rx_done_flag && rx_irq_enable && $past(rx_done_flag, 4)
        && $past(rx_irq_enable, 4) |-> irq_vector == rx_vec_strap)
        else $error("receiver not served first");
    rx_request_a: assert property (rx_done_flag && rx_irq_enable && !bus_grant |-> ##[1:4] bus_request)
        else $error("receiver request missing");
    init_clear_a: assert property (bus_init |-> ##[1:2] csr_rdata[6:3] == 4'h0 && !csr_rdata[0])
        else $error("control bits kept over init");
    fill_sync_only_a: assert property ($rose(csr_rdata[15]) |-> sync_mode)
        else $error("fill flag outside synchronous mode");
endmodule // stc_tx_monitor

// file: test/stc_modem_model.sv
// modem side receiver sampling the transmit line on a strobe
`timescale 1ns/1ns
module stc_modem_model
(
    input  logic        sys_clk,
    input  logic        serial_out,
    input  logic        take,
    output logic [15:0] rx_bits
);
    // shift in one line bit per strobe, first bit ends lowest
    initial rx_bits = 16'h0000;
    always @(posedge sys_clk)
        if (take)
            rx_bits <= {serial_out, rx_bits[15:1]};
endmodule // stc_modem_model

// file: test/test_sync_tx_control_and_irq.sv
// testbench for the transmitter control block
`timescale 1ns/1ns
module test_sync_tx_control_and_irq;
    logic        sys_clk = 0, reset_n = 0, bus_init = 0, csr_wr = 0, csr_rd = 0, dbuf_wr = 0, take = 0;
    logic        parity_en = 0, parity_odd = 0, sync_mode = 0, bus_grant = 0, rx_done_flag = 0, rx_irq_enable = 0;
    logic        modem_status_change_flag = 0, modem_change_irq_enable = 0;
    logic [15:0] csr_wdata = 16'h0000;
    logic [7:0]  dbuf_wdata = 8'h00;
    logic [1:0]  char_len = 2'h3;
    logic [2:0]  prio_strap = 3'h5;
    logic [5:0]  rx_vec_strap = 6'h0A, tx_vec_strap = 6'h15;
    wire  [15:0] csr_rdata, rx_bits;
    wire         dbuf_ready, bus_request, irq_vector_valid, serial_out, receiver_disable, loop_test_input_bit;
    wire  [2:0]  bus_level;
    wire  [5:0]  irq_vector;
    int          n_mismatch = 0, cmp_count = 0;
    stc_tx_ctrl i_dut (.*);
    stc_modem_model i_modem (.*);
    always #20 sys_clk = ~sys_clk;
    task automatic complete_run();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    function automatic logic sig(input int k);
        case (k)
            0: return bus_request;
            1: return dbuf_ready;
            2: return csr_rdata[15];
            3: return irq_vector_valid;
            default: return !serial_out;
        endcase
    endfunction
    // bounded wait for one of the watched outputs
    task automatic wait_for(input int k, input int lim);
        for (int i = 0; i < lim && sig(k) !== 1'b1; i++) cyc(1);
        if (sig(k) !== 1'b1)
        begin
            n_mismatch++;
            $display("[FAIL] wait %0d expected 1 seen 0", k);
            complete_run();
        end
    endtask
    task automatic wcsr(input logic [15:0] v);
        csr_wdata = v;
        csr_wr = 1;
        cyc(1);
        csr_wr = 0;
        cyc(1);
    endtask
    task automatic wbuf(input logic [7:0] d);
        wait_for(1, 50);
        dbuf_wdata = d;
        dbuf_wr = 1;
        cyc(1);
        dbuf_wr = 0;
    endtask
    task automatic grant(input logic [5:0] v);
        wait_for(0, 200);
        chk("level", 16'h0005, bus_level);
        bus_grant = 1;
        wait_for(3, 20);
        chk("vector", v, irq_vector);
        bus_grant = 0;
        rx_done_flag = 0;
        cyc(2);
    endtask
    task automatic s_regs();
        chk("reset status", 16'h0080, csr_rdata & 16'h80F9);
        wcsr(16'h0039);
        cyc(2);
        chk("control bits", 16'h0039, csr_rdata & 16'h0079);
        chk("rx disable", 16'h0001, receiver_disable);
        chk("space", 16'h0000, serial_out);
        bus_init = 1;
        cyc(1);
        bus_init = 0;
        cyc(2);
        chk("init clear", 16'h0000, csr_rdata & 16'h0079);
        wcsr(16'h0069);
        wcsr(16'h0100);
        cyc(2);
        chk("master reset", 16'h0080, csr_rdata & 16'h80F9);
        wcsr(16'h4001);
        cyc(2);
        chk("loop bit", 16'h0001, loop_test_input_bit);
        chk("loop space", 16'h0000, serial_out);
        chk("loop readback", 16'h4001, csr_rdata & 16'h4001);
    endtask
    task automatic s_tx(input logic [7:0] d, input int nb, input logic [15:0] e);
        wcsr(16'h0010);
        wbuf(d);
        wait_for(4, 60);
        cyc(2);
        repeat (nb)
        begin
            take = 1;
            cyc(1);
            take = 0;
            cyc(3);
        end
        chk("serial char", e, rx_bits >> (16 - nb));
        chk("masked request", 16'h0000, bus_request);
    endtask
    task automatic s_irq();
        wcsr(16'h0050);
        rx_irq_enable = 1;
        rx_done_flag = 1;
        wbuf(8'hFF);
        cyc(60);
        grant(rx_vec_strap);
        grant(tx_vec_strap);
    endtask
    task automatic s_fill();
        sync_mode = 1;
        wcsr(16'h0030);
        wbuf(8'h55);
        wait_for(2, 200);
        grant(tx_vec_strap);
        sync_mode = 0;
        wcsr(16'h0100);
    endtask
    task automatic s_buf();
        int n;
        n = 0;
        wcsr(16'h0010);
        while (dbuf_ready === 1'b1 && n < 6)
        begin
            dbuf_wdata = 8'hC3;
            dbuf_wr = 1;
            cyc(1);
            n++;
        end
        dbuf_wr = 0;
        chk("buffer full", 16'h0000, dbuf_ready);
        cyc(200);
        chk("drained", 16'h0001, dbuf_ready);
    endtask
    // reset, then the scenarios in turn
    initial
    begin
        cyc(8);
        reset_n = 1;
        cyc(2);
        s_regs();
        s_tx(8'h4A, 8, 16'h004A);
        char_len = 2'h0;
        parity_en = 1;
        parity_odd = 1;
        s_tx(8'hF2, 6, 16'h0032);
        char_len = 2'h3;
        parity_en = 0;
        parity_odd = 0;
        s_irq();
        s_fill();
        s_buf();
        complete_run();
    end
endmodule // test_sync_tx_control_and_irq
bind stc_tx_ctrl stc_tx_monitor i_mon (.*);
